// File: logic/mcp_codec.sv
// MFM write encoder with precompensation, fault logic and read decoder
//
// Summary of operation
// RL1 - Cell period 206.6 ns sets timing
// RL2 - A one flips flux at mid-cell
// RL3 - Zero flips at cell end unless next one
// RL4 - Retime data and gate: host, then servo clock
// RL5 - Halve servo clock, two-phase shifts two registers
// RL6 - Encoder reads four-bit register A
// RL7 - Encoded stream leaves; three taps return
// RL8 - Exactly one tap gated to write output
// RL9 - All ones or zeros are constant frequency
// RL10 - 011 rising, 110 falling, overlaps included
// RL11 - Constant frequency selects nominal tap
// RL12 - Falling frequency selects early tap
// RL13 - Rising frequency selects late tap
// RL14 - Fault on not-ready, read, unsafe, offtrack
// RL15 - Idle read selects reference phase detector
// RL16 - Active read selects data phase detector
// RL17 - Halved oscillator gives two read phases
// RL18 - Boost low for 58 bits at read start
// RL19 - Controller sends sync field before data
// RL20 - Early/late requests shift read phase
// RL21 - Read pulses synchronized, decoded, delivered
// RL22 - Controller gates are active low
// RL23 - Controller sends data with write clock
// RL24 - Pulse in data half decodes one
// RL25 - Fault sticks, blocks writing until released; the code also clears it on a software clear while the gate is held
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module mcp_codec
  import mcp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic host_write_clock_i,
  input wire logic nrz_wdata_i,
  input wire logic write_gate_n_i,
  input wire logic phase_locked_osc_i,
  input wire logic tuned_oscillator_i,
  input wire logic read_gate_n_i,
  input wire logic read_pulse_i,
  input wire logic drive_ready_i,
  input wire logic unsafe_i,
  input wire logic offtrack_i,
  input wire logic shift_early_n_i,
  input wire logic shift_late_n_i,
  input wire logic tap_early_i,
  input wire logic tap_nom_i,
  input wire logic tap_late_i,
  output logic mfm_o,
  output logic [2:0] tap_sel_o,
  output logic write_out_o,
  output logic write_select_o,
  output logic write_fault_o,
  output logic pd_data_sel_o,
  output logic pd_early_o,
  output logic pd_late_o,
  output logic boost_n_o,
  output logic read_clock_phase0_o,
  output logic read_clock_phase1_o,
  output logic read_nrz_o,
  output logic read_strobe_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  // =====================================================================
  // Functions
  // Tap choice for a mid-cell flux change, window prev/cur/next
  function automatic logic [2:0] classify(input logic [2:0] win);
    logic [2:0] sel;
    sel = SEL_NOM; // [RL9] [RL11]
    if (win == 3'h3)
    begin
      sel = SEL_LATE; // [RL10] [RL13]
    end
    else if (win == 3'h6)
    begin
      sel = SEL_EARLY; // [RL10] [RL12]
    end
    return sel;
  endfunction

  // =====================================================================
  // Input synchronizers
  mcp_pins_t pins_raw;
  mcp_pins_t sync1;
  mcp_pins_t sync2;
  mcp_pins_t sync_prev;

  assign pins_raw = '{host_write_clock: host_write_clock_i,
    nrz_wdata: nrz_wdata_i, write_gate_n: write_gate_n_i,
    phase_locked_osc: phase_locked_osc_i,
    tuned_oscillator: tuned_oscillator_i, read_gate_n: read_gate_n_i,
    read_pulse: read_pulse_i, drive_ready: drive_ready_i,
    unsafe: unsafe_i, offtrack: offtrack_i,
    shift_early_n: shift_early_n_i, shift_late_n: shift_late_n_i,
    tap_early: tap_early_i, tap_nom: tap_nom_i, tap_late: tap_late_i};

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync1 <= '1;
      sync2 <= '1;
      sync_prev <= '1;
    end
    else
    begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync_prev <= sync2;
    end
  end

  logic hwc_rise;
  logic servo_rise;
  logic osc_rise;
  logic pulse_rise;
  assign hwc_rise = sync2.host_write_clock & ~sync_prev.host_write_clock;
  assign servo_rise = sync2.phase_locked_osc & ~sync_prev.phase_locked_osc;
  assign osc_rise = sync2.tuned_oscillator & ~sync_prev.tuned_oscillator;
  assign pulse_rise = sync2.read_pulse & ~sync_prev.read_pulse;

  // =====================================================================
  // Write retiming and two-phase shift registers
  logic wd_host;
  logic wg_host;
  logic wd_retimed;
  logic wg_retimed;
  logic cell_phase;
  logic [3:0] sreg_a;
  logic [3:0] sreg_b;
  logic phase_a;
  logic phase_b;
  // Servo clock runs at half-cell rate, so halving it gives the cell
  assign phase_a = servo_rise & cell_phase;
  assign phase_b = servo_rise & ~cell_phase;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wd_host <= 1'b0;
      wg_host <= 1'b0;
      wd_retimed <= 1'b0;
      wg_retimed <= 1'b0;
    end
    else
    begin
      if (hwc_rise)
      begin
        wd_host <= sync2.nrz_wdata; // [RL4]
        wg_host <= ~sync2.write_gate_n; // [RL4]
      end
      if (servo_rise)
      begin
        wd_retimed <= wd_host; // [RL4]
        wg_retimed <= wg_host; // [RL4]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cell_phase <= 1'b0;
      sreg_a <= 4'h0;
      sreg_b <= 4'h0;
    end
    else
    begin
      if (servo_rise)
      begin
        cell_phase <= ~cell_phase; // [RL1] [RL5]
      end
      if (phase_a)
      begin
        sreg_a <= {sreg_a[2:0], wd_retimed}; // [RL5] [RL6]
      end
      if (phase_b)
      begin
        sreg_b <= sreg_a; // [RL5]
      end
    end
  end

  // =====================================================================
  // Write fault, sticky until gate release or software clear
  mcp_fault_t cause;
  mcp_fault_t fault_cause;
  logic next_fault;
  logic clr_pulse;
  logic precomp_en;
  logic rd_active;
  logic emit;
  assign rd_active = ~sync2.read_gate_n;
  assign cause = '{not_ready: ~sync2.drive_ready, read_on: rd_active,
    unsafe: sync2.unsafe, offtrack: sync2.offtrack};

  always_comb
  begin
    next_fault = write_fault_o;
    if (!wg_retimed || clr_pulse)
    begin
      next_fault = 1'b0; // [RL25]
    end
    if (wg_retimed && (|cause))
    begin
      next_fault = 1'b1; // Set beats clear [RL14]
    end
  end
  assign emit = wg_retimed & ~next_fault; // [RL25]

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      write_fault_o <= 1'b0;
      fault_cause <= '0;
      write_select_o <= 1'b0;
    end
    else
    begin
      write_fault_o <= next_fault;
      write_select_o <= emit; // [RL25]
      if (wg_retimed && (|cause))
      begin
        fault_cause <= cause; // [RL14]
      end
    end
  end

  // =====================================================================
  // MFM encoder and precompensation select
  logic tap_level;
  always_comb
  begin
    tap_level = sync2.tap_nom;
    if (tap_sel_o == SEL_EARLY)
    begin
      tap_level = sync2.tap_early;
    end
    else if (tap_sel_o == SEL_LATE)
    begin
      tap_level = sync2.tap_late;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mfm_o <= 1'b0;
      tap_sel_o <= SEL_NOM;
      write_out_o <= 1'b0;
    end
    else
    begin
      if (emit && phase_b && sreg_a[1])
      begin
        mfm_o <= ~mfm_o; // [RL2] [RL7]
        // Window spans both registers: prev, cur from B, next from A
        if (precomp_en)
        begin
          tap_sel_o <= classify({sreg_b[1:0], sreg_a[0]}); // [RL8]
        end
        else
        begin
          tap_sel_o <= SEL_NOM;
        end
      end
      else if (emit && phase_a && (sreg_a[1:0] == 2'h0))
      begin
        mfm_o <= ~mfm_o; // [RL3] [RL7]
        tap_sel_o <= SEL_NOM; // [RL11]
      end
      // Taps only exist as returned copies; sampled, not re-timed to 12 ns
      write_out_o <= emit & tap_level; // [RL8]
    end
  end

  // =====================================================================
  // Read phase-locked loop control
  mcp_rd_state_t rd_state;
  logic [BOOST_W-1:0] rd_cnt;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_state <= RD_IDLE;
      rd_cnt <= '0;
      boost_n_o <= 1'b1;
    end
    else
    begin
      case (rd_state)
        RD_IDLE:
        begin
          if (rd_active)
          begin
            rd_state <= RD_BOOST;
            rd_cnt <= '0;
            boost_n_o <= 1'b0; // [RL18]
          end
        end
        RD_BOOST:
        begin
          if (!rd_active)
          begin
            rd_state <= RD_IDLE;
            boost_n_o <= 1'b1;
          end
          else if (rd_cnt == BOOST_W'(BOOST_CYC - 1))
          begin
            rd_state <= RD_TRACK; // [RL1] [RL18]
            boost_n_o <= 1'b1;
          end
          else
          begin
            rd_cnt <= rd_cnt + 1'b1;
          end
        end
        RD_TRACK:
        begin
          if (!rd_active)
          begin
            rd_state <= RD_IDLE;
          end
        end
        default:
        begin
          rd_state <= RD_IDLE;
          boost_n_o <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pd_data_sel_o <= 1'b0;
      pd_early_o <= 1'b0;
      pd_late_o <= 1'b0;
    end
    else
    begin
      pd_data_sel_o <= rd_active; // [RL15] [RL16]
      // Early wins if the controller asks for both
      pd_early_o <= rd_active & ~sync2.shift_early_n; // [RL20]
      pd_late_o <= rd_active & sync2.shift_early_n
        & ~sync2.shift_late_n; // [RL20]
    end
  end

  // =====================================================================
  // Read clock phases and MFM decoder
  logic data_hit;
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      read_clock_phase0_o <= 1'b1;
      read_clock_phase1_o <= 1'b0;
      data_hit <= 1'b0;
      read_nrz_o <= 1'b0;
      read_strobe_o <= 1'b0;
    end
    else
    begin
      read_strobe_o <= 1'b0;
      if (osc_rise)
      begin
        read_clock_phase0_o <= read_clock_phase1_o; // [RL17]
        read_clock_phase1_o <= ~read_clock_phase1_o; // [RL17]
      end
      if (osc_rise && read_clock_phase1_o)
      begin
        read_nrz_o <= rd_active & (data_hit | pulse_rise); // [RL21] [RL24]
        read_strobe_o <= rd_active; // [RL21]
        data_hit <= 1'b0;
      end
      else if (pulse_rise && read_clock_phase1_o)
      begin
        data_hit <= 1'b1; // [RL24]
      end
    end
  end

  // =====================================================================
  // AXI4-Lite slave
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic hs_aw;
  logic hs_w;
  logic hs_ar;
  assign hs_aw = s_axi_awvalid_i & s_axi_awready_o;
  assign hs_w = s_axi_wvalid_i & s_axi_wready_o;
  assign hs_ar = s_axi_arvalid_i & s_axi_arready_o;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      precomp_en <= CTRL_PCE_RST;
      clr_pulse <= 1'b0;
    end
    else
    begin
      clr_pulse <= 1'b0;
      s_axi_awready_o <= ~(aw_got | hs_aw);
      s_axi_wready_o <= ~(w_got | hs_w);
      if (hs_aw)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (hs_w)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid_o)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= RESP_OKAY;
        if (aw_addr == ADDR_CTRL)
        begin
          if (w_strb[0])
          begin
            precomp_en <= w_data[CTRL_PCE_BIT];
            clr_pulse <= w_data[CTRL_CLR_BIT];
          end
        end
        else if (aw_addr != ADDR_STAT)
        begin
          s_axi_bresp_o <= RESP_SLVERR;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready_o <= ~(s_axi_rvalid_o | hs_ar);
      if (s_axi_rvalid_o && s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
      end
      if (hs_ar)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= '0;
        s_axi_rresp_o <= RESP_OKAY;
        if (s_axi_araddr_i == ADDR_CTRL)
        begin
          s_axi_rdata_o[CTRL_PCE_BIT] <= precomp_en;
        end
        else if (s_axi_araddr_i == ADDR_STAT)
        begin
          s_axi_rdata_o[STAT_FAULT_BIT] <= write_fault_o;
          s_axi_rdata_o[STAT_CAUSE_LSB +: 4] <= fault_cause;
          s_axi_rdata_o[STAT_WG_BIT] <= wg_retimed;
          s_axi_rdata_o[STAT_RD_BIT] <= rd_active;
          s_axi_rdata_o[STAT_BOOST_BIT] <= ~boost_n_o;
          s_axi_rdata_o[STAT_PCE_BIT] <= precomp_en;
        end
        else
        begin
          s_axi_rresp_o <= RESP_SLVERR;
        end
      end
    end
  end

  // =====================================================================
  // Assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic [BOOST_W:0] low_len;
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      low_len <= '0;
    end
    else
    begin
      low_len <= boost_n_o ? '0 : low_len + 1'b1;
    end
  end

  chk_boost_len: assert property ( // [RL18]
    $rose(boost_n_o) && rd_state == RD_TRACK |-> low_len == BOOST_CYC)
    else $error("boost pulse length wrong");
  chk_pd_select: assert property ( // [RL15] [RL16]
    ##1 pd_data_sel_o == $past(rd_active))
    else $error("phase detector select wrong");
  chk_fault_set: assert property ( // [RL14]
    wg_retimed && (|cause) |=> write_fault_o)
    else $error("write fault not raised");
  chk_fault_hold: assert property ( // [RL25]
    write_fault_o && wg_retimed && !clr_pulse |=> write_fault_o)
    else $error("write fault dropped early");
  chk_fault_block: assert property ( // [RL25]
    write_fault_o |-> !write_select_o && !write_out_o)
    else $error("write active during fault");
  chk_tap_onehot: assert property ( // [RL8]
    $onehot(tap_sel_o))
    else $error("tap select not one-hot");
  chk_rise_late: assert property ( // [RL13]
    emit && phase_b && precomp_en && sreg_a[2:0] == 3'h3
    |=> tap_sel_o == SEL_LATE)
    else $error("rising pattern not late");
  chk_fall_early: assert property ( // [RL12]
    emit && phase_b && precomp_en && sreg_a[2:0] == 3'h6
    |=> tap_sel_o == SEL_EARLY)
    else $error("falling pattern not early");
  chk_mid_one: assert property ( // [RL2]
    emit && phase_b && sreg_a[1] |=> mfm_o != $past(mfm_o))
    else $error("no mid-cell flux change for one");
  chk_zero_end: assert property ( // [RL3]
    phase_a && sreg_a[1:0] != 2'h0 |=> $stable(mfm_o))
    else $error("cell-end flux change before one");
  chk_read_phase: assert property ( // [RL17]
    read_clock_phase0_o != read_clock_phase1_o)
    else $error("read phases not complementary");
  chk_retime: assert property ( // [RL4]
    servo_rise |=> wd_retimed == $past(wd_host))
    else $error("servo retime missed");

  cov_boost_done: cover property ($rose(boost_n_o) && rd_state == RD_TRACK);
  cov_fault: cover property ($rose(write_fault_o));
  cov_late: cover property (tap_sel_o == SEL_LATE);
  cov_read_one: cover property (read_strobe_o && read_nrz_o);

endmodule

// File: common/mcp_pkg.sv
// Shared constants, types and carriers of the MFM codec data path
package mcp_pkg;

  // =====================================================================
  // Timing
  localparam int CLK_TENTH_NS = 500;
  localparam int CELL_TENTH_NS = 2066;
  localparam int TAP_NOM_NS = 12;
  localparam int TAP_LATE_NS = 24;
  localparam int BOOST_BITS = 58;
  localparam int BOOST_CYC = (BOOST_BITS * CELL_TENTH_NS) / CLK_TENTH_NS;
  localparam int BOOST_W = 8;

  // =====================================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_PCE_BIT = 1;
  localparam logic CTRL_PCE_RST = 1'b1;
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_CAUSE_LSB = 1;
  localparam int STAT_WG_BIT = 5;
  localparam int STAT_RD_BIT = 6;
  localparam int STAT_BOOST_BIT = 7;
  localparam int STAT_PCE_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // =====================================================================
  // Delay tap selection, one-hot
  localparam logic [2:0] SEL_EARLY = 3'h1;
  localparam logic [2:0] SEL_NOM = 3'h2;
  localparam logic [2:0] SEL_LATE = 3'h4;

  typedef enum logic [2:0] {
    RD_IDLE = 3'h1,
    RD_BOOST = 3'h2,
    RD_TRACK = 3'h4
  } mcp_rd_state_t;

  typedef struct packed {
    logic not_ready;
    logic read_on;
    logic unsafe;
    logic offtrack;
  } mcp_fault_t;

  // Pins from outside the core clock domain
  typedef struct packed {
    logic host_write_clock;
    logic nrz_wdata;
    logic write_gate_n;
    logic phase_locked_osc;
    logic tuned_oscillator;
    logic read_gate_n;
    logic read_pulse;
    logic drive_ready;
    logic unsafe;
    logic offtrack;
    logic shift_early_n;
    logic shift_late_n;
    logic tap_early;
    logic tap_nom;
    logic tap_late;
  } mcp_pins_t;

endpackage

// File: tb/mcp_ctrl_model.sv
// Behavioural disk controller, servo clocks and delay line for the codec
`timescale 1ns/100ps
module mcp_ctrl_model
(
  input wire logic frame_i,
  input wire logic rd_i,
  input wire logic [31:0] pattern_i,
  input wire logic mfm_i,
  output logic host_write_clock_o,
  output logic nrz_wdata_o,
  output logic phase_locked_osc_o,
  output logic tuned_oscillator_o,
  output logic read_pulse_o,
  output logic tap_early_o,
  output logic tap_nom_o,
  output logic tap_late_o
);
  int unsigned idx;
  initial
  begin
    host_write_clock_o = 1'b0;
    nrz_wdata_o = 1'b0;
    phase_locked_osc_o = 1'b0;
    tuned_oscillator_o = 1'b0;
    read_pulse_o = 1'b0;
    idx = 0;
  end
  // =====================================================
  // Oscillators, one rise per half cell, unrelated phase
  always #100 phase_locked_osc_o = ~phase_locked_osc_o;
  always #100.5 tuned_oscillator_o = ~tuned_oscillator_o;
  // Sync field of steady pulses while reading
  always #200 read_pulse_o = rd_i & ~read_pulse_o;
  // =====================================================
  // Write clock only inside frames; data set up a half period early
  always
  begin
    if (frame_i)
    begin
      nrz_wdata_o = pattern_i[idx % 32];
      #200 host_write_clock_o = 1'b1;
      #200 host_write_clock_o = 1'b0;
      idx++;
    end
    else
    begin
      // Released line wanders, never holds the last bit
      #50 nrz_wdata_o = ~nrz_wdata_o;
      idx = 0;
    end
  end
  // Delay line copies
  assign tap_early_o = mfm_i;
  assign #12 tap_nom_o = mfm_i;
  assign #24 tap_late_o = mfm_i;
endmodule

// File: tb/mcp_codec_precomp_read_sync_bench.sv
// Self-checking bench for the MFM codec and read sync block
`timescale 1ns/100ps
module mcp_codec_precomp_read_sync_bench
  import mcp_pkg::*;
;
  logic clk, arst_n, wg_n, rg_n, rdy, uns, off, se_n, sl_n, frame;
  logic hwc, nrz, sosc, rosc, rpulse, te, tn, tl;
  logic mfm, wout, wsel, wfault, pd_sel, pd_e, pd_l, boost_n;
  logic ph0, ph1, rnrz, strobe, pce;
  logic [2:0] tap_sel, seen, mfm_q;
  logic [31:0] pat, wdata, rdata;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awv, awr, wv, wr_rdy, bv, bready, arv, arr, rv, rready;
  logic [1:0] bresp, rresp, resp;
  int err_total, samples_checked, tog;

  mcp_ctrl_model mcp_ctrl_model_i (.frame_i(frame), .rd_i(~rg_n),
    .pattern_i(pat), .mfm_i(mfm), .host_write_clock_o(hwc),
    .nrz_wdata_o(nrz), .phase_locked_osc_o(sosc),
    .tuned_oscillator_o(rosc), .read_pulse_o(rpulse),
    .tap_early_o(te), .tap_nom_o(tn), .tap_late_o(tl));

  mcp_codec mcp_codec_i (.core_clk_i(clk), .arst_n_i(arst_n),
    .host_write_clock_i(hwc), .nrz_wdata_i(nrz), .write_gate_n_i(wg_n),
    .phase_locked_osc_i(sosc), .tuned_oscillator_i(rosc),
    .read_gate_n_i(rg_n), .read_pulse_i(rpulse), .drive_ready_i(rdy),
    .unsafe_i(uns), .offtrack_i(off), .shift_early_n_i(se_n),
    .shift_late_n_i(sl_n), .tap_early_i(te), .tap_nom_i(tn),
    .tap_late_i(tl), .mfm_o(mfm), .tap_sel_o(tap_sel),
    .write_out_o(wout), .write_select_o(wsel), .write_fault_o(wfault),
    .pd_data_sel_o(pd_sel), .pd_early_o(pd_e), .pd_late_o(pd_l),
    .boost_n_o(boost_n), .read_clock_phase0_o(ph0),
    .read_clock_phase1_o(ph1), .read_nrz_o(rnrz),
    .read_strobe_o(strobe), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rready));

  always #25 clk = ~clk;

  // =====================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return wfault;
      1: return pd_sel;
      2: return boost_n;
      default: return strobe;
    endcase
  endfunction

  // Bounded wait for a design output to reach a level
  task automatic wait_v(input int k, input logic v);
    int n;
    n = 0;
    while (pick(k) !== v && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    chk(pick(k), v);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      n++;
    end
    while (!bv && n < 100);
    if (!bv) err_total++;
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      n++;
    end
    while (!rv && n < 100);
    if (!rv) err_total++;
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Flux changes per 32-cell pass of a circular pattern
  function automatic int exp_tog(input logic [31:0] p);
    int t;
    t = 0;
    for (int i = 0; i < 32; i++)
      t += (p[i] || !p[(i + 1) % 32]) ? 1 : 0;
    return t;
  endfunction

  // Taps a pattern should call for, read as prev, cur, next
  function automatic logic [2:0] exp_sel(input logic [31:0] p);
    logic [2:0] s, k;
    s = SEL_NOM;
    for (int i = 0; i < 32; i++)
    begin
      k = {p[(i + 31) % 32], p[i], p[(i + 1) % 32]};
      if (k == 3'b011) s |= SEL_LATE;
      if (k == 3'b110) s |= SEL_EARLY;
    end
    return s;
  endfunction

  always @(posedge clk)
  begin
    if (mfm !== mfm_q[0]) tog++;
    // Write output trails the encoder by the two tap syncs and its flop
    if (wsel) chk(wout, mfm_q[2]);
    mfm_q = {mfm_q[1:0], mfm};
    seen = seen | tap_sel;
    if (!wg_n && arst_n) chk($onehot(tap_sel), 1'b1);
  end

  // Window is 256 cycles, exactly 32 cells of 400 ns
  task automatic run_pat(input logic [31:0] p);
    pat <= p;
    wg_n <= 1'b0;
    repeat (80) @(posedge clk);
    tog = 0;
    seen = 3'h0;
    repeat (256) @(posedge clk);
    chk((tog - exp_tog(p)) inside {[-2:2]}, 1'b1);
    chk(seen, pce ? exp_sel(p) : SEL_NOM);
    chk(wsel, 1'b1);
    wg_n <= 1'b1;
    repeat (30) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run is near 2800 cycles; seven times that is a hang
  initial
  begin
    #1000000;
    err_total++;
    finish_test();
  end

  // =====================================================
  // Main sequence
  initial
  begin
    int n;
    {clk, arst_n, rdy, uns, off, frame, awv, wv, arv} = 9'h0;
    {wg_n, rg_n, se_n, sl_n, pce} = 5'h1F;
    {bready, rready, pat, wdata, awaddr, araddr} = '0;
    err_total = 0;
    samples_checked = 0;
    mfm_q = '0;
    void'($urandom(32'h6CCF));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rdy <= 1'b1;
    repeat (2) @(posedge clk);
    chk({tap_sel, boost_n, wfault, pd_sel}, {SEL_NOM, 3'h4});
    rd(ADDR_STAT, wdata);
    chk({resp, wdata[STAT_PCE_BIT]}, {RESP_OKAY, CTRL_PCE_RST});
    rd(8'h10, wdata);
    chk({resp, wdata}, {RESP_SLVERR, 32'h0});
    wr(8'h20, $urandom());
    chk(resp, RESP_SLVERR);
    // Read start: data detector and boost window
    rg_n <= 1'b0;
    wait_v(2, 1'b0);
    n = 0;
    while (boost_n === 1'b0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk(n, BOOST_CYC);
    chk(pd_sel, 1'b1);
    chk(ph0 ^ ph1, 1'b1);
    wait_v(3, 1'b1);
    se_n <= 1'b0;
    sl_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({pd_e, pd_l}, 2'h2);
    se_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk({pd_e, pd_l}, 2'h1);
    sl_n <= 1'b1;
    rg_n <= 1'b1;
    wait_v(1, 1'b0);
    // Each fault cause, cleared by register or by gate release
    frame <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rdy <= (i != 0);
      rg_n <= (i != 1);
      uns <= (i == 2);
      off <= (i == 3);
      wg_n <= 1'b0;
      wait_v(0, 1'b1);
      chk(wsel, 1'b0);
      {rdy, rg_n, uns, off} <= 4'hC;
      repeat (8) @(posedge clk);
      chk(wfault, 1'b1);
      if (i % 2 == 1)
        wg_n <= 1'b1;
      else
        wr(ADDR_CTRL, 32'h3);
      wait_v(0, 1'b0);
      wg_n <= 1'b1;
      repeat (30) @(posedge clk);
    end
    chk({rnrz, strobe}, 2'h0);
    // Encoder and precompensation patterns, one drawn at random
    run_pat(32'hFFFFFFFF);
    run_pat(32'h0);
    run_pat(32'h55555555);
    run_pat(32'hB6DB6DB6);
    run_pat($urandom());
    // Precompensation off: every flux change on the nominal tap
    pce = 1'b0;
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_CTRL, wdata);
    chk({resp, wdata}, {RESP_OKAY, 32'h0});
    run_pat(32'hB6DB6DB6);
    finish_test();
  end
endmodule
